// file: dv/testbench.sv
`timescale 1ns/10ps
`include "crm_defines.svh"
module testbench;
   logic                   pclk;
   logic                   presetn;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [`CRM_AW-1:0]     paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [7:0]             timer_cfg;
   logic [7:0]             irq_control_reg;
   logic                   sw_reset_flag_n;
   logic                   sw_reset_req;
   logic [`CRM_PC_W-1:0]   pc_q;
   int                     bad_count;
   int                     cmp_count;
   int                     req_seen;
   int                     lat_one;
   logic [31:0]            rd;
   logic                   err;
   int                     lat;

   crm_core i_crm_core
   (
      .pclk            (pclk),
      .presetn         (presetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .timer_cfg       (timer_cfg),
      .irq_control_reg (irq_control_reg),
      .sw_reset_flag_n (sw_reset_flag_n),
      .sw_reset_req    (sw_reset_req),
      .pc_q            (pc_q)
   );

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // request pulses are counted so a missed or doubled one shows up
   always @(posedge pclk)
   begin
      if (sw_reset_req === 1'b1)
         req_seen++;
   end

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // request held from setup until pready is sampled high
   task automatic apb_go(input logic w, input logic [11:0] a,
                         input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      lat = 0;
      // no local limit: the watchdog ends a hung wait
      do
      begin
         @(posedge pclk);
         lat++;
      end
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
   endtask

   // ports are looked at 1 ns after the answer edge, once settled
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      apb_go(w, a, d);
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   function automatic logic [31:0] mk(input logic [3:0] op,
                                      input logic [7:0] lit,
                                      input logic [6:0] fa,
                                      input logic d);
      mk = {12'h000, d, fa, lit, op};
   endfunction

   // pc read follows the command at once, so a busy core delays its answer
   task automatic exec(input logic [31:0] cmd, input logic [14:0] exp_pc);
      @(posedge pclk);
      apb_go(1'b1, `CRM_OFF_CMD, cmd);
      apb_go(1'b0, `CRM_OFF_PC, 32'h0);
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
      chk("pc read", rd, {17'h0, exp_pc});
      chk("pc port", {17'h0, pc_q}, {17'h0, exp_pc});
   endtask

   task automatic t_reset_vals();
      chk("tcfg rst", {24'h0, timer_cfg}, 32'h0000_00FF);
      chk("irq rst", {24'h0, irq_control_reg}, 32'h0000_0000);
      chk("flag rst", {31'h0, sw_reset_flag_n}, 32'h0000_0001);
      chk("pc rst", {17'h0, pc_q}, 32'h0000_0000);
   endtask

   task automatic t_idle();
      apb(1'b1, `CRM_OFF_ACC, 32'h0000_003C);
      apb(1'b1, `CRM_OFF_STAT, 32'h0000_0001);
      apb(1'b1, `CRM_OFF_PC, 32'h0000_0100);
      exec(mk(`CRM_OP_IDLE, 8'hFF, 7'h7F, 1'b1), 15'h0101);
      lat_one = lat;
      apb(1'b0, `CRM_OFF_ACC, 32'h0);
      chk("idle acc", rd, 32'h0000_003C);
      apb(1'b0, `CRM_OFF_STAT, 32'h0);
      chk("idle carry", {31'h0, rd[0]}, 32'h1);
      chk("idle tcfg", {24'h0, timer_cfg}, 32'h0000_00FF);
   endtask

   task automatic t_load_cfg();
      apb(1'b1, `CRM_OFF_ACC, 32'h0000_00A5);
      exec(mk(`CRM_OP_LOAD_CFG, 8'h00, 7'h00, 1'b0), 15'h0102);
      chk("cfg port", {24'h0, timer_cfg}, 32'h0000_00A5);
      apb(1'b0, `CRM_OFF_TCFG, 32'h0);
      chk("cfg read", rd, 32'h0000_00A5);
      apb(1'b0, `CRM_OFF_STAT, 32'h0);
      chk("cfg carry", {31'h0, rd[0]}, 32'h1);
      apb(1'b1, `CRM_OFF_TCFG, 32'h0000_0011);
      chk("tcfg ro", {24'h0, timer_cfg}, 32'h0000_00A5);
   endtask

   task automatic t_returns();
      apb(1'b1, `CRM_OFF_STACK, 32'h0000_0345);
      apb(1'b1, `CRM_OFF_STACK, 32'h0000_0234);
      apb(1'b1, `CRM_OFF_STACK, 32'h0000_7123);
      exec(mk(`CRM_OP_IRQ_RET, 8'h00, 7'h00, 1'b0), 15'h7123);
      chk("irq ret lat", lat, lat_one + 1);
      chk("gie", {31'h0, irq_control_reg[`CRM_GIE_BIT]}, 32'h1);
      apb(1'b0, `CRM_OFF_STACK, 32'h0);
      chk("depth", {27'h0, rd[20:16]}, 32'h2);
      exec(mk(`CRM_OP_SUB_RET, 8'h00, 7'h00, 1'b0), 15'h0234);
      chk("sub ret lat", lat, lat_one + 1);
      apb(1'b0, `CRM_OFF_STAT, 32'h0);
      chk("sub carry", {31'h0, rd[0]}, 32'h1);
      exec(mk(`CRM_OP_RET_LIT, 8'hFF, 7'h00, 1'b0), 15'h0345);
      chk("lit lat", lat, lat_one + 1);
      apb(1'b0, `CRM_OFF_ACC, 32'h0);
      chk("lit acc", rd, 32'h0000_00FF);
      apb(1'b0, `CRM_OFF_STAT, 32'h0);
      chk("lit carry", {31'h0, rd[0]}, 32'h1);
   endtask

   task automatic t_rotate();
      // bank 1, file 10: index 90, byte address 800 + 240
      apb(1'b1, `CRM_OFF_BANK, 32'h0000_0001);
      apb(1'b1, 12'hA40, 32'h0000_00E6);
      // same 7-bit address in bank 0 must stay untouched
      apb(1'b1, 12'h840, 32'h0000_005A);
      apb(1'b1, `CRM_OFF_STAT, 32'h0000_0000);
      exec(mk(`CRM_OP_ROT_LEFT, 8'h00, 7'h10, 1'b0), 15'h0346);
      chk("rot lat", lat, lat_one);
      apb(1'b0, `CRM_OFF_ACC, 32'h0);
      chk("rot acc", rd, 32'h0000_00CC);
      apb(1'b0, 12'hA40, 32'h0);
      chk("rot src", rd, 32'h0000_00E6);
      apb(1'b0, `CRM_OFF_STAT, 32'h0);
      chk("rot carry", {31'h0, rd[0]}, 32'h1);
      exec(mk(`CRM_OP_ROT_LEFT, 8'h00, 7'h10, 1'b1), 15'h0347);
      apb(1'b0, 12'hA40, 32'h0);
      chk("rot file", rd, 32'h0000_00CD);
      apb(1'b0, `CRM_OFF_ACC, 32'h0);
      chk("rot acc kept", rd, 32'h0000_00CC);
      apb(1'b0, 12'h840, 32'h0);
      chk("bank 0 file", rd, 32'h0000_005A);
   endtask

   task automatic t_sw_reset();
      req_seen = 0;
      exec(mk(`CRM_OP_SW_RESET, 8'h00, 7'h00, 1'b0), 15'h0000);
      chk("req pulses", req_seen, 32'h1);
      chk("flag port", {31'h0, sw_reset_flag_n}, 32'h0);
      chk("tcfg back", {24'h0, timer_cfg}, 32'h0000_00FF);
      chk("irq back", {24'h0, irq_control_reg}, 32'h0);
      apb(1'b0, `CRM_OFF_PWR, 32'h0);
      chk("pwr read", {31'h0, rd[0]}, 32'h0);
      apb(1'b0, `CRM_OFF_ACC, 32'h0);
      chk("acc back", rd, 32'h0);
      apb(1'b0, `CRM_OFF_BANK, 32'h0);
      chk("bank back", rd, 32'h0);
      apb(1'b1, `CRM_OFF_PWR, 32'h0000_0001);
      chk("flag set", {31'h0, sw_reset_flag_n}, 32'h1);
   endtask

   task automatic t_unmapped();
      apb(1'b1, 12'h030, 32'h0000_0055);
      chk("wr slverr", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h030, 32'h0);
      chk("rd slverr", {31'h0, err}, 32'h1);
      chk("rd data", rd, 32'h0);
      // undefined opcode behaves as the idle instruction
      exec(mk(4'hF, 8'h00, 7'h00, 1'b0), 15'h0001);
      apb(1'b0, `CRM_OFF_ACC, 32'h0);
      chk("mapped ok", {31'h0, err}, 32'h0);
      chk("undef acc", rd, 32'h0);
   endtask

   initial
   begin
      bad_count = 0;
      cmp_count = 0;
      req_seen  = 0;
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = '0;
      pwdata    = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      t_reset_vals();
      t_idle();
      t_load_cfg();
      t_returns();
      t_rotate();
      t_sw_reset();
      t_unmapped();
      finish_test();
   end

   // the whole sequence needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      finish_test();
   end
endmodule

// file: rtl/crm_core.sv
// Contract
// - load-config copies the accumulator to the timer config, no flags.
// - software reset resets the device and clears sw_reset_flag_n.
// - interrupt_return pops the stack and loads stack_top into pc.
// - interrupt_return sets global_irq_enable, two cycles, one word.
// - subroutine return pops to pc in two cycles, no flags changed.
// - return_literal loads its 8-bit literal into the accumulator.
// - return_literal also loads pc from stack_top, in two cycles.
// - rotate_left_carry shifts left through carry, only carry moves.
// - rotate_left_carry with dest 0 writes the accumulator only.
// - rotate_left_carry with dest 1 writes back the file register.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "crm_defines.svh"
module crm_core
#(
   parameter int BANK_BITS   = 2,
   parameter int STACK_DEPTH = 16
)
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [`CRM_AW-1:0]    paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic      [7:0]            timer_cfg,
   output logic      [7:0]            irq_control_reg,
   output logic                       sw_reset_flag_n,
   output logic                       sw_reset_req,
   output logic      [`CRM_PC_W-1:0]  pc_q
);
   import crm_pkg::*;

   localparam int FIDX_W = `CRM_FADDR_W + BANK_BITS;
   localparam int SCW    = $clog2(STACK_DEPTH + 1);

   crm_state_e                state_q;
   logic [`CRM_CMD_W-1:0]     ir_q;
   logic [7:0]                acc_q;
   logic                      carry_q;
   logic [BANK_BITS-1:0]      bank_q;
   logic [7:0]                file_mem [1 << FIDX_W];
   logic [`CRM_PC_W-1:0]      stack_top;
   logic [SCW-1:0]            stack_cnt;

   logic [3:0]                op;
   logic [7:0]                lit;
   logic                      dest;
   logic [FIDX_W-1:0]         fidx;
   logic [7:0]                src_byte;
   logic [7:0]                rot_byte;
   logic [`CRM_PC_W-1:0]      pc_inc;
   logic                      exec;
   logic                      is_ret;
   logic                      acc_ph;
   logic                      take;
   logic                      wr;
   logic                      hit;
   logic [31:0]               rdata;

   assign op       = ir_q[`CRM_F_OP_MSB:`CRM_F_OP_LSB];
   assign lit      = ir_q[`CRM_F_LIT_MSB:`CRM_F_LIT_LSB];
   assign dest     = ir_q[`CRM_F_DEST_BIT];
   // 7-bit operand always lands inside the current bank
   assign fidx     = {bank_q, ir_q[`CRM_F_FADDR_MSB:`CRM_F_FADDR_LSB]};
   assign src_byte = file_mem[fidx];
   assign rot_byte = {src_byte[6:0], carry_q};
   assign pc_inc   = pc_q + `CRM_PC_W'(1);
   assign exec     = (state_q == CRM_ST_EXEC);
   assign is_ret   = (op == `CRM_OP_IRQ_RET) || (op == `CRM_OP_SUB_RET) ||
                     (op == `CRM_OP_RET_LIT);

   // bus waits while an instruction runs, so no write races the core
   assign acc_ph = psel && penable;
   assign take   = acc_ph && !pready && (state_q == CRM_ST_IDLE);
   assign wr     = acc_ph && pready && pwrite;

   always_comb
   begin
      hit   = 1'b1;
      rdata = '0;
      if (paddr[`CRM_FILE_SEL_BIT])
         rdata[7:0] = file_mem[paddr[FIDX_W+1:2]];
      else
         unique case (paddr)
            `CRM_OFF_CMD:   rdata[`CRM_CMD_W-1:0] = ir_q;
            `CRM_OFF_ACC:   rdata[7:0] = acc_q;
            `CRM_OFF_PC:    rdata[`CRM_PC_W-1:0] = pc_q;
            `CRM_OFF_STAT:
            begin
               rdata[`CRM_STAT_CARRY_BIT] = carry_q;
               rdata[`CRM_STAT_BUSY_BIT]  = (state_q != CRM_ST_IDLE);
            end
            `CRM_OFF_TCFG:  rdata[7:0] = timer_cfg;
            `CRM_OFF_IRQ:   rdata[7:0] = irq_control_reg;
            `CRM_OFF_PWR:   rdata[`CRM_PWR_SWRST_BIT] = sw_reset_flag_n;
            `CRM_OFF_STACK:
            begin
               rdata[`CRM_PC_W-1:0] = stack_top;
               rdata[`CRM_STK_CNT_LSB +: SCW] = stack_cnt;
            end
            `CRM_OFF_BANK:  rdata[BANK_BITS-1:0] = bank_q;
            default:        hit = 1'b0;
         endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= take;
         pslverr <= take && !hit;
         if (take)
            prdata <= rdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ir_q <= '0;
      else if (wr && paddr == `CRM_OFF_CMD)
         ir_q <= pwdata[`CRM_CMD_W-1:0];
   end

   // returns hold one dead cycle for the refetch after the pc jump
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_q <= CRM_ST_IDLE;
      else
         unique case (state_q)
            CRM_ST_IDLE:
               if (wr && paddr == `CRM_OFF_CMD)
                  state_q <= CRM_ST_EXEC;
            CRM_ST_EXEC:
               state_q <= is_ret ? CRM_ST_EXEC2 : CRM_ST_IDLE;
            CRM_ST_EXEC2:
               state_q <= CRM_ST_IDLE;
         endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pc_q <= `CRM_PC_RST;
      else if (wr && paddr == `CRM_OFF_PC)
         pc_q <= pwdata[`CRM_PC_W-1:0];
      else if (exec)
      begin
         if (op == `CRM_OP_SW_RESET)
            pc_q <= `CRM_PC_RST;
         else if (is_ret)
            pc_q <= stack_top;
         else
            pc_q <= pc_inc;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc_q <= `CRM_ACC_RST;
      else if (wr && paddr == `CRM_OFF_ACC)
         acc_q <= pwdata[7:0];
      else if (exec)
      begin
         if (op == `CRM_OP_SW_RESET)
            acc_q <= `CRM_ACC_RST;
         else if (op == `CRM_OP_RET_LIT)
            acc_q <= lit;
         else if (op == `CRM_OP_ROT_LEFT && !dest)
            acc_q <= rot_byte;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         carry_q <= 1'b0;
      else if (wr && paddr == `CRM_OFF_STAT)
         carry_q <= pwdata[`CRM_STAT_CARRY_BIT];
      else if (exec && op == `CRM_OP_SW_RESET)
         carry_q <= 1'b0;
      else if (exec && op == `CRM_OP_ROT_LEFT)
         carry_q <= src_byte[7];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_cfg <= `CRM_TCFG_RST;
      else if (exec && op == `CRM_OP_SW_RESET)
         timer_cfg <= `CRM_TCFG_RST;
      else if (exec && op == `CRM_OP_LOAD_CFG)
         timer_cfg <= acc_q;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_control_reg <= `CRM_IRQ_RST;
      else if (wr && paddr == `CRM_OFF_IRQ)
         irq_control_reg <= pwdata[7:0];
      else if (exec && op == `CRM_OP_SW_RESET)
         irq_control_reg <= `CRM_IRQ_RST;
      else if (exec && op == `CRM_OP_IRQ_RET)
         irq_control_reg[`CRM_GIE_BIT] <= 1'b1;
   end

   // flag survives its own reset so software can find the cause
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sw_reset_flag_n <= 1'b1;
      else if (exec && op == `CRM_OP_SW_RESET)
         sw_reset_flag_n <= 1'b0;
      else if (wr && paddr == `CRM_OFF_PWR)
         sw_reset_flag_n <= pwdata[`CRM_PWR_SWRST_BIT];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sw_reset_req <= 1'b0;
      else
         sw_reset_req <= exec && op == `CRM_OP_SW_RESET;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bank_q <= '0;
      else if (wr && paddr == `CRM_OFF_BANK)
         bank_q <= pwdata[BANK_BITS-1:0];
      else if (exec && op == `CRM_OP_SW_RESET)
         bank_q <= '0;
   end

   // data memory is not cleared by any reset
   always_ff @(posedge pclk)
   begin
      if (wr && paddr[`CRM_FILE_SEL_BIT])
         file_mem[paddr[FIDX_W+1:2]] <= pwdata[7:0];
      else if (exec && op == `CRM_OP_ROT_LEFT && dest)
         file_mem[fidx] <= rot_byte;
   end

   crm_stack
   #(
      .DEPTH     (STACK_DEPTH),
      .WIDTH     (`CRM_PC_W),
      .CW        (SCW)
   )
   u_stack
   (
      .clk       (pclk),
      .rst_n     (presetn),
      .clr       (exec && op == `CRM_OP_SW_RESET),
      .push      (wr && paddr == `CRM_OFF_STACK),
      .push_data (pwdata[`CRM_PC_W-1:0]),
      .pop       (exec && is_ret),
      .stack_top (stack_top),
      .depth     (stack_cnt)
   );

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_two_cycle;
      state_q == CRM_ST_EXEC2 ##1 state_q == CRM_ST_IDLE;
   endsequence

   sequence s_start(logic [3:0] code);
      exec && op == code;
   endsequence

   property p_load_cfg;
      s_start(`CRM_OP_LOAD_CFG) |=>
         timer_cfg == $past(acc_q) && carry_q == $past(carry_q);
   endproperty
   a_load_cfg: assert property (p_load_cfg)
      else $error("timer config not loaded from accumulator");

   property p_sw_reset;
      s_start(`CRM_OP_SW_RESET) |=>
         sw_reset_req && !sw_reset_flag_n && pc_q == `CRM_PC_RST
         ##1 !sw_reset_req;
   endproperty
   a_sw_reset: assert property (p_sw_reset)
      else $error("software reset effects wrong");

   property p_irq_ret;
      s_start(`CRM_OP_IRQ_RET) ##0 stack_cnt != '0 |=>
         pc_q == $past(stack_top) &&
         stack_cnt == SCW'($past(stack_cnt) - SCW'(1));
   endproperty
   a_irq_ret: assert property (p_irq_ret)
      else $error("interrupt return did not pop to pc");

   property p_irq_gie;
      s_start(`CRM_OP_IRQ_RET) |=>
         irq_control_reg[`CRM_GIE_BIT] ##0 s_two_cycle;
   endproperty
   a_irq_gie: assert property (p_irq_gie)
      else $error("interrupt return enable or length wrong");

   property p_sub_ret;
      s_start(`CRM_OP_SUB_RET) |=>
         pc_q == $past(stack_top) && $stable(carry_q) ##0 s_two_cycle;
   endproperty
   a_sub_ret: assert property (p_sub_ret)
      else $error("subroutine return wrong");

   property p_ret_lit_acc;
      s_start(`CRM_OP_RET_LIT) |=> acc_q == $past(lit) && $stable(carry_q);
   endproperty
   a_ret_lit_acc: assert property (p_ret_lit_acc)
      else $error("literal not in accumulator");

   property p_ret_lit_pc;
      s_start(`CRM_OP_RET_LIT) |=> pc_q == $past(stack_top) ##0 s_two_cycle;
   endproperty
   a_ret_lit_pc: assert property (p_ret_lit_pc)
      else $error("literal return pc or length wrong");

   property p_rot_carry;
      s_start(`CRM_OP_ROT_LEFT) |=> carry_q == $past(src_byte[7]);
   endproperty
   a_rot_carry: assert property (p_rot_carry)
      else $error("rotate carry wrong");

   property p_rot_acc;
      s_start(`CRM_OP_ROT_LEFT) ##0 !dest |=>
         acc_q == $past(rot_byte) && file_mem[$past(fidx)] == $past(src_byte);
   endproperty
   a_rot_acc: assert property (p_rot_acc)
      else $error("rotate to accumulator wrong");

   property p_rot_file;
      s_start(`CRM_OP_ROT_LEFT) ##0 dest |=>
         file_mem[$past(fidx)] == $past(rot_byte) && $stable(acc_q);
   endproperty
   a_rot_file: assert property (p_rot_file)
      else $error("rotate to file wrong");

   property p_idle;
      s_start(`CRM_OP_IDLE) |=> pc_q == $past(pc_inc) && $stable(acc_q) &&
         $stable(carry_q) && $stable(timer_cfg) && state_q == CRM_ST_IDLE;
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle instruction changed state");

   property p_rot_len;
      s_start(`CRM_OP_ROT_LEFT) |=> state_q == CRM_ST_IDLE;
   endproperty
   a_rot_len: assert property (p_rot_len)
      else $error("rotate took more than one cycle");
endmodule

// file: rtl/crm_defines.svh
`ifndef CRM_DEFINES_SVH
`define CRM_DEFINES_SVH

`define CRM_AW              12
`define CRM_OFF_CMD         12'h000
`define CRM_OFF_ACC         12'h004
`define CRM_OFF_PC          12'h008
`define CRM_OFF_STAT        12'h00C
`define CRM_OFF_TCFG        12'h010
`define CRM_OFF_IRQ         12'h014
`define CRM_OFF_PWR         12'h018
`define CRM_OFF_STACK       12'h01C
`define CRM_OFF_BANK        12'h020
`define CRM_FILE_SEL_BIT    11

`define CRM_OP_IDLE         4'h0
`define CRM_OP_LOAD_CFG     4'h1
`define CRM_OP_SW_RESET     4'h2
`define CRM_OP_IRQ_RET      4'h3
`define CRM_OP_SUB_RET      4'h4
`define CRM_OP_RET_LIT      4'h5
`define CRM_OP_ROT_LEFT     4'h6

`define CRM_CMD_W           20
`define CRM_F_OP_MSB        3
`define CRM_F_OP_LSB        0
`define CRM_F_LIT_MSB       11
`define CRM_F_LIT_LSB       4
`define CRM_F_FADDR_MSB     18
`define CRM_F_FADDR_LSB     12
`define CRM_F_DEST_BIT      19

`define CRM_STAT_CARRY_BIT  0
`define CRM_STAT_BUSY_BIT   1
`define CRM_GIE_BIT         7
`define CRM_PWR_SWRST_BIT   0
`define CRM_STK_CNT_LSB     16

`define CRM_PC_W            15
`define CRM_FADDR_W         7
`define CRM_PC_RST          15'h0000
`define CRM_ACC_RST         8'h00
`define CRM_TCFG_RST        8'hFF
`define CRM_IRQ_RST         8'h00

`endif

// file: rtl/crm_pkg.sv
package crm_pkg;
   typedef enum logic [2:0]
   {
      CRM_ST_IDLE  = 3'b001,
      CRM_ST_EXEC  = 3'b010,
      CRM_ST_EXEC2 = 3'b100
   } crm_state_e;
endpackage

// file: rtl/crm_stack.sv
`timescale 1ns/10ps
`include "crm_defines.svh"
module crm_stack
#(
   parameter int DEPTH = 16,
   parameter int WIDTH = 15,
   parameter int CW    = $clog2(DEPTH + 1)
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             clr,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] stack_top,
   output logic      [CW-1:0]    depth
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [CW-1:0]    cnt_q;

   // full push is dropped, empty pop is ignored: no silent wrap
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (clr)
         cnt_q <= '0;
      else if (pop && cnt_q != '0)
         cnt_q <= cnt_q - CW'(1);
      else if (push && cnt_q != CW'(DEPTH))
         cnt_q <= cnt_q + CW'(1);
   end

   always_ff @(posedge clk)
   begin
      if (push && !pop && !clr && cnt_q != CW'(DEPTH))
         mem[cnt_q[AW-1:0]] <= push_data;
   end

   always_comb
   begin
      stack_top = '0;
      if (cnt_q != '0)
         stack_top = mem[AW'(cnt_q - CW'(1))];
   end

   assign depth = cnt_q;
endmodule
